// [tbrs_pkg.sv]
/*
  Package for the translation base register set: register indices, field
  positions, reset values and encodings.
  Assumes a plain 32-bit register port; 64-bit registers take two words.
*/
package tbrs_pkg;

  // Word addresses (low word / high word of each 64-bit register)
  localparam logic [7:0] ADR_T0_EL1_LO = 8'h00;
  localparam logic [7:0] ADR_T0_EL1_HI = 8'h04;
  localparam logic [7:0] ADR_T0_EL2_LO = 8'h08;
  localparam logic [7:0] ADR_T0_EL2_HI = 8'h0C;
  localparam logic [7:0] ADR_T0_EL3_LO = 8'h10;
  localparam logic [7:0] ADR_T0_EL3_HI = 8'h14;
  localparam logic [7:0] ADR_T1_EL1_LO = 8'h18;
  localparam logic [7:0] ADR_T1_EL1_HI = 8'h1C;
  localparam logic [7:0] ADR_S2_BASE_LO = 8'h20;
  localparam logic [7:0] ADR_S2_BASE_HI = 8'h24;
  localparam logic [7:0] ADR_VDEF_STAT = 8'h28;
  localparam logic [7:0] ADR_VERR_SYND = 8'h2C;
  localparam logic [7:0] ADR_S2_CTRL = 8'h30;
  localparam logic [7:0] ADR_CONFIG = 8'h34;
  localparam logic [7:0] ADR_EL1_SYND = 8'h38;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h3C;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h40;
  localparam logic [7:0] ADR_T1_EL2_LO = 8'h44;
  localparam logic [7:0] ADR_T1_EL2_HI = 8'h48;

  // Base register fields
  localparam int ADDRESS_SPACE_IDENTIFIER_LSB = 16;        // In the high word, bits 63:48
  localparam logic [31:0] HI_TABLE_BASE_FIELD_MASK = 32'h0000FFFF; // Bits 47:32
  localparam logic [31:0] HI_FULL_MASK = 32'hFFFFFFFF;
  localparam int CNP_BIT = 0;

  // Deferred status and syndrome fields
  localparam int VDS_DEFER_BIT = 31;
  localparam int IDS_BIT = 24;
  localparam logic [31:0] SYND_MASK = 32'h01FFFFFF;  // Bits 24:0
  localparam logic [31:0] VDS_MASK = 32'h81FFFFFF;

  // Stage 2 control: implemented bits 28:25, 22:21, granule 15:14
  localparam logic [31:0] S2_CTRL_MASK = 32'h1E60C000;
  localparam int GRAN_LSB = 14;

  // Config word: bit 0 host extension, bit 1 identifier selector,
  // bits 3:2 EL3 walk sharing
  localparam int CFG_HOST_EXT_BIT = 0;
  localparam int CFG_SEL_BIT = 1;
  localparam int CFG_SHARE_LSB = 2;
  localparam logic [31:0] CFG_MASK = 32'h0000000F;

  // Interrupt status bits
  localparam int IRQ_DEFER_BIT = 0;
  localparam int IRQ_TAKEN_BIT = 1;
  localparam logic [31:0] IRQ_MASK_BITS = 32'h00000003;

  // Reset values of control state
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam int BASE_LSB_MIN = 1;     // Lowest misaligned base bit

  // Walk sharing encodings
  typedef enum logic [1:0]
  {
    SHARE_NON = 2'b00,
    SHARE_RSVD = 2'b01,
    SHARE_OUTER = 2'b10,
    SHARE_INNER = 2'b11
  } tbrs_share_t;

  // Stage 2 granule encodings
  typedef enum logic [1:0]
  {
    GRAN_4K = 2'b00,
    GRAN_64K = 2'b01,
    GRAN_16K = 2'b10,
    GRAN_RSVD = 2'b11
  } tbrs_gran_t;

endpackage

// [tbrs_regword.sv]
/*
  One 32-bit software register word with a field mask; unimplemented
  bits read as zero and ignore writes.
  Assumes write enable is already qualified by clock enable and decode.
*/
`timescale 1ns/1ns
module tbrs_regword #(
  parameter logic [31:0] MASK = 32'hFFFFFFFF
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write side
  input wire logic we,
  input wire logic [31:0] wdata,
  // Stored value
  output logic [31:0] q
);

  logic [31:0] q_ff;

  // Masked storage; reset to zero keeps simulation free of X
  always_ff @(posedge clk)
  begin
    if (!resetn)
      q_ff <= tbrs_pkg::RST_ZERO;
    else if (we)
      q_ff <= wdata & MASK;
  end

  assign q = q_ff;

endmodule

// [tbrs_top.sv]
/*
  Translation base register set: table base registers, stage 2 control,
  virtual deferred error status and syndrome, with walker views.
  Assumes one clock, synchronous active-low reset, and a software master
  that issues single-cycle read or write strobes.
*/
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module tbrs_top
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Core events
  input wire logic error_sync_barrier,
  input wire logic virtual_error_pending,
  input wire logic virt_error_take,
  // Walker inputs: alignment width x per table
  input wire logic [5:0] align_x_t0,
  input wire logic [5:0] align_x_t1,
  input wire logic [5:0] align_x_s2,
  // Walker views
  output logic [47:0] walk_base_el1,
  output logic [47:0] walk_base_el2,
  output logic [47:0] walk_base_el3,
  output logic [47:0] walk_base_s2,
  output logic [15:0] walk_address_space_identifier_el1,
  output logic walk_cnp_el1,
  output logic walk_cnp_s2,
  output logic [1:0] walk_share_el3,
  output logic [1:0] walk_granule_s2,
  output logic walk_granule_bad,
  // Interrupt
  output logic irq
);

  // Storage words
  // Base words keep every written bit except the EL3 table-0 high word, which keeps bits 15:0; the walker masks on the way out
  logic [31:0] t0e1_lo, t0e1_hi, t0e2_lo, t0e2_hi, t0e3_lo, t0e3_hi;
  logic [31:0] t1e1_lo, t1e1_hi, t1e2_lo, t1e2_hi, s2b_lo, s2b_hi;
  logic [31:0] s2ctl, cfg, vsynd;
  logic [31:0] vds_ff, nxt_vds;
  logic [31:0] el1syn_ff, nxt_el1syn;
  logic [31:0] ists_ff, nxt_ists;
  logic [31:0] imsk_ff;
  logic [31:0] rdata_ff, nxt_rdata;
  logic irq_ff;
  logic [47:0] wb_el1_ff, wb_el2_ff, wb_el3_ff, wb_s2_ff;
  logic [15:0] address_space_identifier_ff;
  logic cnp1_ff, cnps2_ff, gbad_ff;
  logic [1:0] sh3_ff, gran_ff;

  // Write decode
  // Strobes count only in enabled cycles, so a frozen block takes nothing
  wire wr = reg_wr & clk_en;
  wire host_ext = cfg[tbrs_pkg::CFG_HOST_EXT_BIT];
  wire we_t0e1_lo = wr & (reg_addr == tbrs_pkg::ADR_T0_EL1_LO);
  wire we_t0e1_hi = wr & (reg_addr == tbrs_pkg::ADR_T0_EL1_HI);
  wire we_t0e2_lo = wr & (reg_addr == tbrs_pkg::ADR_T0_EL2_LO);
  wire we_t0e2_hi = wr & (reg_addr == tbrs_pkg::ADR_T0_EL2_HI);
  wire we_t0e3_lo = wr & (reg_addr == tbrs_pkg::ADR_T0_EL3_LO);
  wire we_t0e3_hi = wr & (reg_addr == tbrs_pkg::ADR_T0_EL3_HI);
  wire we_t1e1_lo = wr & (reg_addr == tbrs_pkg::ADR_T1_EL1_LO);
  wire we_t1e1_hi = wr & (reg_addr == tbrs_pkg::ADR_T1_EL1_HI);
  wire we_t1e2_lo = wr & (reg_addr == tbrs_pkg::ADR_T1_EL2_LO);
  wire we_t1e2_hi = wr & (reg_addr == tbrs_pkg::ADR_T1_EL2_HI);
  wire we_s2b_lo = wr & (reg_addr == tbrs_pkg::ADR_S2_BASE_LO);
  wire we_s2b_hi = wr & (reg_addr == tbrs_pkg::ADR_S2_BASE_HI);
  wire we_s2ctl = wr & (reg_addr == tbrs_pkg::ADR_S2_CTRL);
  wire we_cfg = wr & (reg_addr == tbrs_pkg::ADR_CONFIG);
  wire we_vsynd = wr & (reg_addr == tbrs_pkg::ADR_VERR_SYND);
  wire we_vds = wr & (reg_addr == tbrs_pkg::ADR_VDEF_STAT);
  wire we_el1syn = wr & (reg_addr == tbrs_pkg::ADR_EL1_SYND);
  wire we_ists = wr & (reg_addr == tbrs_pkg::ADR_IRQ_STAT);
  wire we_imsk = wr & (reg_addr == tbrs_pkg::ADR_IRQ_MASK);

  // Low words keep every written bit, including misaligned ones
  tbrs_regword #(.MASK(tbrs_pkg::HI_FULL_MASK)) u_t0e1_lo
  (.clk(clk), .resetn(resetn),
   .we(we_t0e1_lo), .wdata(reg_wdata),
   .q(t0e1_lo));
  tbrs_regword #(.MASK(tbrs_pkg::HI_FULL_MASK)) u_t0e1_hi
  (.clk(clk), .resetn(resetn),
   .we(we_t0e1_hi), .wdata(reg_wdata),
   .q(t0e1_hi));
  tbrs_regword #(.MASK(tbrs_pkg::HI_FULL_MASK)) u_t0e2_lo
  (.clk(clk), .resetn(resetn),
   .we(we_t0e2_lo), .wdata(reg_wdata),
   .q(t0e2_lo));
  // Identifier bits are stored but only visible with host extension
  tbrs_regword #(.MASK(tbrs_pkg::HI_FULL_MASK)) u_t0e2_hi
  (.clk(clk), .resetn(resetn),
   .we(we_t0e2_hi), .wdata(reg_wdata),
   .q(t0e2_hi));
  tbrs_regword #(.MASK(tbrs_pkg::HI_FULL_MASK)) u_t0e3_lo
  (.clk(clk), .resetn(resetn),
   .we(we_t0e3_lo), .wdata(reg_wdata),
   .q(t0e3_lo));
  tbrs_regword #(.MASK(tbrs_pkg::HI_TABLE_BASE_FIELD_MASK)) u_t0e3_hi
  (.clk(clk), .resetn(resetn),
   .we(we_t0e3_hi), .wdata(reg_wdata),
   .q(t0e3_hi));
  tbrs_regword #(.MASK(tbrs_pkg::HI_FULL_MASK)) u_t1e1_lo
  (.clk(clk), .resetn(resetn),
   .we(we_t1e1_lo), .wdata(reg_wdata),
   .q(t1e1_lo));
  tbrs_regword #(.MASK(tbrs_pkg::HI_FULL_MASK)) u_t1e1_hi
  (.clk(clk), .resetn(resetn),
   .we(we_t1e1_hi), .wdata(reg_wdata),
   .q(t1e1_hi));
  // EL2 table-1 is a full twin of the EL1 table-1 layout
  tbrs_regword #(.MASK(tbrs_pkg::HI_FULL_MASK)) u_t1e2_lo
  (.clk(clk), .resetn(resetn),
   .we(we_t1e2_lo), .wdata(reg_wdata),
   .q(t1e2_lo));
  tbrs_regword #(.MASK(tbrs_pkg::HI_FULL_MASK)) u_t1e2_hi
  (.clk(clk), .resetn(resetn),
   .we(we_t1e2_hi), .wdata(reg_wdata),
   .q(t1e2_hi));
  tbrs_regword #(.MASK(tbrs_pkg::HI_FULL_MASK)) u_s2b_lo
  (.clk(clk), .resetn(resetn),
   .we(we_s2b_lo), .wdata(reg_wdata),
   .q(s2b_lo));
  tbrs_regword #(.MASK(tbrs_pkg::HI_FULL_MASK)) u_s2b_hi
  (.clk(clk), .resetn(resetn),
   .we(we_s2b_hi), .wdata(reg_wdata),
   .q(s2b_hi));
  // Only the implemented control bits are kept
  tbrs_regword #(.MASK(tbrs_pkg::S2_CTRL_MASK)) u_s2ctl
  (.clk(clk), .resetn(resetn),
   .we(we_s2ctl), .wdata(reg_wdata),
   .q(s2ctl));
  tbrs_regword #(.MASK(tbrs_pkg::CFG_MASK)) u_cfg
  (.clk(clk), .resetn(resetn),
   .we(we_cfg), .wdata(reg_wdata),
   .q(cfg));
  tbrs_regword #(.MASK(tbrs_pkg::SYND_MASK)) u_vsynd
  (.clk(clk), .resetn(resetn),
   .we(we_vsynd), .wdata(reg_wdata),
   .q(vsynd));

  // Hardware events, qualified by clock enable
  // An event in a frozen cycle is lost; the core must hold it until enabled
  wire ev_defer = clk_en & error_sync_barrier;
  wire ev_take = clk_en & virt_error_take & virtual_error_pending;

  // Deferred status: hardware capture wins over a same-cycle write
  // Flag and syndrome move together, so software never reads half a record
  always_comb
  begin
    nxt_vds = vds_ff;
    if (we_vds)
      nxt_vds = reg_wdata & tbrs_pkg::VDS_MASK;
    if (ev_defer)
    begin
      nxt_vds = vsynd & tbrs_pkg::SYND_MASK;
      nxt_vds[tbrs_pkg::VDS_DEFER_BIT] = 1'b1;
    end
  end

  // EL1 syndrome copy of type bit and syndrome field
  always_comb
  begin
    nxt_el1syn = el1syn_ff;
    if (we_el1syn)
      nxt_el1syn = reg_wdata & tbrs_pkg::SYND_MASK;
    if (ev_take)
      nxt_el1syn = vsynd & tbrs_pkg::SYND_MASK;
  end

  // Sticky interrupt status; set wins over write-one-to-clear
  // A clear racing an event would otherwise lose that event
  always_comb
  begin
    nxt_ists = ists_ff;
    if (we_ists)
      nxt_ists = ists_ff & ~(reg_wdata & tbrs_pkg::IRQ_MASK_BITS);
    if (ev_defer)
      nxt_ists[tbrs_pkg::IRQ_DEFER_BIT] = 1'b1;
    if (ev_take)
      nxt_ists[tbrs_pkg::IRQ_TAKEN_BIT] = 1'b1;
  end

  // Event registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      vds_ff <= tbrs_pkg::RST_ZERO;
      el1syn_ff <= tbrs_pkg::RST_ZERO;
      ists_ff <= tbrs_pkg::RST_ZERO;
      imsk_ff <= tbrs_pkg::RST_ZERO;
    end
    else
    begin
      vds_ff <= nxt_vds;
      el1syn_ff <= nxt_el1syn;
      ists_ff <= nxt_ists;
      if (we_imsk)
        imsk_ff <= reg_wdata & tbrs_pkg::IRQ_MASK_BITS;
    end
  end

  // Read views: EL2 table-0 hides the identifier unless host extension
  wire [31:0] t0e2_hi_view = host_ext ? t0e2_hi
                                      : (t0e2_hi & tbrs_pkg::HI_TABLE_BASE_FIELD_MASK);
  wire rd = reg_rd & clk_en;

  // Read mux; unmapped addresses return zero
  // Reads have no side effects, so a repeated read is harmless
  always_comb
  begin
    unique case (reg_addr)
      tbrs_pkg::ADR_T0_EL1_LO: nxt_rdata = t0e1_lo;
      tbrs_pkg::ADR_T0_EL1_HI: nxt_rdata = t0e1_hi;
      tbrs_pkg::ADR_T0_EL2_LO: nxt_rdata = t0e2_lo;
      tbrs_pkg::ADR_T0_EL2_HI: nxt_rdata = t0e2_hi_view;
      tbrs_pkg::ADR_T0_EL3_LO: nxt_rdata = t0e3_lo;
      tbrs_pkg::ADR_T0_EL3_HI: nxt_rdata = t0e3_hi;
      tbrs_pkg::ADR_T1_EL1_LO: nxt_rdata = t1e1_lo;
      tbrs_pkg::ADR_T1_EL1_HI: nxt_rdata = t1e1_hi;
      tbrs_pkg::ADR_T1_EL2_LO: nxt_rdata = t1e2_lo;
      tbrs_pkg::ADR_T1_EL2_HI: nxt_rdata = t1e2_hi;
      tbrs_pkg::ADR_S2_BASE_LO: nxt_rdata = s2b_lo;
      tbrs_pkg::ADR_S2_BASE_HI: nxt_rdata = s2b_hi;
      tbrs_pkg::ADR_VDEF_STAT: nxt_rdata = vds_ff;
      tbrs_pkg::ADR_VERR_SYND: nxt_rdata = vsynd;
      tbrs_pkg::ADR_S2_CTRL: nxt_rdata = s2ctl;
      tbrs_pkg::ADR_CONFIG: nxt_rdata = cfg;
      tbrs_pkg::ADR_EL1_SYND: nxt_rdata = el1syn_ff;
      tbrs_pkg::ADR_IRQ_STAT: nxt_rdata = ists_ff;
      tbrs_pkg::ADR_IRQ_MASK: nxt_rdata = imsk_ff;
      default: nxt_rdata = tbrs_pkg::RST_ZERO;
    endcase
  end

  // Alignment masks: bits x-1 down to 1 cleared for the walker
  function automatic logic [47:0] align_base(input logic [31:0] hi,
                                             input logic [31:0] lo,
                                             input logic [5:0] x);
    logic [47:0] base;
    logic [47:0] keep;
    base = {hi[15:0], lo};
    // Bit 0 is the flag, never address, even for a tiny exponent
    keep = (48'hFFFFFFFFFFFF << x) & 48'hFFFFFFFFFFFE;
    align_base = base & keep;
  endfunction

  wire [47:0] nb_el1 = align_base(t0e1_hi, t0e1_lo,
                                  align_x_t0);
  wire [47:0] nb_el2 = align_base(t0e2_hi, t0e2_lo, align_x_t0);
  wire [47:0] nb_el3 = align_base(t0e3_hi, t0e3_lo, align_x_t0);
  wire [47:0] nb_s2 = align_base(s2b_hi, s2b_lo, align_x_s2);
  wire [47:0] nb_t1 = align_base(t1e1_hi, t1e1_lo, align_x_t1);
  wire sel_t1 = cfg[tbrs_pkg::CFG_SEL_BIT];
  wire [15:0] nxt_address_space_identifier = sel_t1 ? t1e1_hi[31:16] : t0e1_hi[31:16];
  wire [1:0] gran = s2ctl[tbrs_pkg::GRAN_LSB +: 2];
  wire [1:0] share = cfg[tbrs_pkg::CFG_SHARE_LSB +: 2];

  // Walker view registers, frozen while clock enable is low
  // The extra register costs a cycle of lag but keeps walker paths short
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wb_el1_ff <= '0;
      wb_el2_ff <= '0;
      wb_el3_ff <= '0;
      wb_s2_ff <= '0;
      address_space_identifier_ff <= '0;
      cnp1_ff <= 1'b0;
      cnps2_ff <= 1'b0;
      sh3_ff <= 2'b00;
      gran_ff <= 2'b00;
      gbad_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      wb_el1_ff <= sel_t1 ? nb_t1 : nb_el1;
      wb_el2_ff <= nb_el2;
      wb_el3_ff <= nb_el3;
      wb_s2_ff <= nb_s2;
      address_space_identifier_ff <= nxt_address_space_identifier;
      cnp1_ff <= t0e1_lo[tbrs_pkg::CNP_BIT];
      cnps2_ff <= s2b_lo[tbrs_pkg::CNP_BIT];
      sh3_ff <= share;
      gran_ff <= gran;
      gbad_ff <= (gran == tbrs_pkg::GRAN_RSVD);
    end
  end

  // Read data and interrupt output
  // The line follows the next status, so it rises with the captured event
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdata_ff <= tbrs_pkg::RST_ZERO;
      irq_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata_ff <= rd ? nxt_rdata : tbrs_pkg::RST_ZERO;
      irq_ff <= |(nxt_ists & imsk_ff);
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;
  assign walk_base_el1 = wb_el1_ff;
  assign walk_base_el2 = wb_el2_ff;
  assign walk_base_el3 = wb_el3_ff;
  assign walk_base_s2 = wb_s2_ff;
  assign walk_address_space_identifier_el1 = address_space_identifier_ff;
  assign walk_cnp_el1 = cnp1_ff;
  assign walk_cnp_s2 = cnps2_ff;
  assign walk_share_el3 = sh3_ff;
  assign walk_granule_s2 = gran_ff;
  assign walk_granule_bad = gbad_ff;

endmodule

// [tbrs_monitor.sv]
/*
  Checker for the translation base register set: port-level relations
  between the register port, the event inputs and the walker views.
  Assumes it is bound to tbrs_top and that the alignment inputs are
  held steady by whoever drives them.
*/
`timescale 1ns/1ns
module tbrs_monitor
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Core events
  input wire logic error_sync_barrier,
  input wire logic virtual_error_pending,
  input wire logic virt_error_take,
  // Walker side
  input wire logic [5:0] align_x_t0,
  input wire logic [5:0] align_x_s2,
  input wire logic [47:0] walk_base_el3,
  input wire logic [47:0] walk_base_s2,
  input wire logic walk_cnp_s2,
  input wire logic [1:0] walk_share_el3,
  input wire logic [1:0] walk_granule_s2,
  input wire logic walk_granule_bad,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Anything that may legally raise the interrupt line
  wire irq_cause = clk_en && (error_sync_barrier || reg_wr ||
    (virt_error_take && virtual_error_pending));

  // Bits below the alignment exponent, never shown to the walker
  function automatic logic [47:0] low_bits(input logic [5:0] x);
    return (48'h000000000001 << x) - 48'h000000000001;
  endfunction

  // Read data only stands in the cycle after a read strobe
  a_rdata_idle_zero: assert property (
    clk_en && !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero outside a read answer");
  a_unmapped_read_zero: assert property (
    clk_en && reg_rd && reg_addr == 8'h4C |=> reg_rdata == 32'h00000000)
    else $error("unmapped read returned nonzero data");
  a_granule_bad_flag: assert property (
    walk_granule_bad == (walk_granule_s2 == 2'h3))
    else $error("granule reserved flag disagrees with granule field");
  a_irq_has_cause: assert property (
    $rose(irq) |-> $past(irq_cause, 1) || $past(irq_cause, 2))
    else $error("interrupt rose without an event or a write");
  a_defer_read_flag: assert property (
    clk_en && error_sync_barrier ##1
    clk_en && reg_rd && reg_addr == tbrs_pkg::ADR_VDEF_STAT
    |=> reg_rdata[31])
    else $error("deferred status flag not set after barrier");
  // Views move only after a write or an alignment change, never on their own
  a_views_hold: assert property (
    clk_en && !reg_wr && $stable(align_x_s2) ##1
    clk_en && !reg_wr && $stable(align_x_s2)
    |=> $stable(walk_base_s2) && $stable(walk_cnp_s2) &&
    $stable(walk_share_el3))
    else $error("walker view changed with no write");
  a_s2_aligned: assert property (
    (clk_en && $stable(align_x_s2))[*3]
    |-> (walk_base_s2 & low_bits(align_x_s2)) == 48'h000000000000)
    else $error("stage 2 walker base has bits below alignment");
  a_el3_aligned: assert property (
    (clk_en && $stable(align_x_t0))[*3]
    |-> (walk_base_el3 & low_bits(align_x_t0)) == 48'h000000000000)
    else $error("EL3 walker base has bits below alignment");
endmodule

bind tbrs_top tbrs_monitor u_tbrs_monitor (.clk, .resetn, .clk_en,
  .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .error_sync_barrier,
  .virtual_error_pending, .virt_error_take, .align_x_t0, .align_x_s2,
  .walk_base_el3, .walk_base_s2, .walk_cnp_s2, .walk_share_el3,
  .walk_granule_s2, .walk_granule_bad, .irq);

// [tb_tbrs.sv]
/*
  Self-checking testbench for the translation base register set.
  Assumes the register port answers one cycle after a read strobe and
  walker views settle two cycles after a write.
*/
`timescale 1ns/1ns
module testbench;
  // Stimulus and observed outputs
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic barrier = 1'b0;
  logic pend = 1'b0;
  logic take = 1'b0;
  logic en = 1'b1;
  logic [5:0] ax2 = 6'h0C;
  logic [31:0] reg_rdata;
  logic [47:0] wb_el1, wb_el2, wb_el3, wb_s2;
  logic [15:0] wasid;
  logic wcnp1, wcnp2, wbad, irq;
  logic [1:0] wshare, wgran;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  tbrs_top u_tbrs_top (.clk(clk), .resetn(resetn), .clk_en(en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .error_sync_barrier(barrier),
    .virtual_error_pending(pend), .virt_error_take(take),
    .align_x_t0(6'h0C), .align_x_t1(6'h10), .align_x_s2(ax2),
    .walk_base_el1(wb_el1), .walk_base_el2(wb_el2), .walk_base_el3(wb_el3),
    .walk_base_s2(wb_s2), .walk_address_space_identifier_el1(wasid), .walk_cnp_el1(wcnp1),
    .walk_cnp_s2(wcnp2), .walk_share_el3(wshare), .walk_granule_s2(wgran),
    .walk_granule_bad(wbad), .irq(irq));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [47:0] e,
    input logic [47:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is taken just after the answering edge has settled
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, reg_rdata});
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // One-cycle event pulse: 0 barrier, 1 virtual error taken
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0)
      barrier <= 1'b1;
    else
      take <= 1'b1;
    @(posedge clk);
    barrier <= 1'b0;
    take <= 1'b0;
  endtask

  task automatic t_bases;
    for (int a = 0; a <= 72; a += 4)
      rchk(8'(a), 32'h00000000);
    wr(tbrs_pkg::ADR_T0_EL1_LO, 32'h0000F0F1);
    wr(tbrs_pkg::ADR_T0_EL1_HI, 32'hABCD1234);
    rchk(tbrs_pkg::ADR_T0_EL1_LO, 32'h0000F0F1);
    rchk(tbrs_pkg::ADR_T0_EL1_HI, 32'hABCD1234);
    settle;
    chk("walk_base_el1", 48'h12340000F000, wb_el1);
    chk("walk_cnp_el1", 48'h000000000001, {47'h0, wcnp1});
    chk("walk_address_space_identifier_el1", 48'h00000000ABCD, {32'h0, wasid});
    wr(tbrs_pkg::ADR_T1_EL1_LO, 32'h00012345);
    wr(tbrs_pkg::ADR_T1_EL1_HI, 32'h5555000A);
    wr(tbrs_pkg::ADR_CONFIG, 32'h00000002);
    settle;
    chk("walk_address_space_identifier_el1", 48'h000000005555, {32'h0, wasid});
    chk("walk_base_el1", 48'h000A00010000, wb_el1);
  endtask

  task automatic t_upper;
    wr(tbrs_pkg::ADR_T0_EL3_HI, 32'hFFFFFFFF);
    rchk(tbrs_pkg::ADR_T0_EL3_HI, 32'h0000FFFF);
    wr(tbrs_pkg::ADR_T0_EL2_HI, 32'hFFFFFFFF);
    wr(tbrs_pkg::ADR_CONFIG, 32'h00000000);
    rchk(tbrs_pkg::ADR_T0_EL2_HI, 32'h0000FFFF);
    wr(tbrs_pkg::ADR_CONFIG, 32'h00000001);
    rchk(tbrs_pkg::ADR_T0_EL2_HI, 32'hFFFFFFFF);
    wr(tbrs_pkg::ADR_T1_EL2_HI, 32'hFFFFFFFF);
    rchk(tbrs_pkg::ADR_T1_EL2_HI, 32'hFFFFFFFF);
    wr(tbrs_pkg::ADR_T1_EL2_LO, 32'h0000F0F1);
    rchk(tbrs_pkg::ADR_T1_EL2_LO, 32'h0000F0F1);
    wr(tbrs_pkg::ADR_T0_EL3_LO, 32'h00000FFF);
    settle;
    chk("walk_base_el3", 48'hFFFF00000000, wb_el3);
    chk("walk_base_el2", 48'hFFFF00000000, wb_el2);
  endtask

  // Every granule and sharing code, plus the stage 2 base flag
  task automatic t_codes;
    wr(tbrs_pkg::ADR_S2_CTRL, 32'hFFFFFFFF);
    rchk(tbrs_pkg::ADR_S2_CTRL, 32'h1E60C000);
    for (int g = 0; g < 4; g++)
    begin
      wr(tbrs_pkg::ADR_S2_CTRL, 32'(g) << 14);
      settle;
      chk("walk_granule_s2", 48'(g), {46'h0, wgran});
      chk("walk_granule_bad", 48'(g == 3), {47'h0, wbad});
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(tbrs_pkg::ADR_CONFIG, 32'(s) << 2);
      settle;
      chk("walk_share_el3", 48'(s), {46'h0, wshare});
    end
    wr(tbrs_pkg::ADR_S2_BASE_LO, 32'h00001FF1);
    rchk(tbrs_pkg::ADR_S2_BASE_LO, 32'h00001FF1);
    settle;
    chk("walk_cnp_s2", 48'h000000000001, {47'h0, wcnp2});
    chk("walk_base_s2", 48'h000000001000, wb_s2);
    // A smaller exponent lets more of the written base through
    @(posedge clk);
    ax2 <= 6'h08;
    settle;
    chk("walk_base_s2", 48'h000000001F00, wb_s2);
  endtask

  // Deferral back to back with a status read, then interrupt handling
  task automatic t_errors;
    wr(tbrs_pkg::ADR_VERR_SYND, 32'hFFFFFFFF);
    rchk(tbrs_pkg::ADR_VERR_SYND, 32'h01FFFFFF);
    wr(tbrs_pkg::ADR_IRQ_MASK, 32'h00000001);
    @(posedge clk);
    barrier <= 1'b1;
    @(posedge clk);
    barrier <= 1'b0;
    reg_addr <= tbrs_pkg::ADR_VDEF_STAT;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("deferred status", 48'h81FFFFFF, {16'h0, reg_rdata});
    chk("irq", 48'h000000000001, {47'h0, irq});
    rchk(tbrs_pkg::ADR_IRQ_STAT, 32'h00000001);
    wr(tbrs_pkg::ADR_IRQ_STAT, 32'h00000001);
    wr(tbrs_pkg::ADR_IRQ_MASK, 32'h00000000);
    pulse(0);
    settle;
    chk("irq", 48'h000000000000, {47'h0, irq});
    wr(tbrs_pkg::ADR_VERR_SYND, 32'h01ABCDEF);
    pulse(1);
    rchk(tbrs_pkg::ADR_EL1_SYND, 32'h00000000);
    @(posedge clk);
    pend <= 1'b1;
    pulse(1);
    rchk(tbrs_pkg::ADR_EL1_SYND, 32'h01ABCDEF);
    rchk(tbrs_pkg::ADR_IRQ_STAT, 32'h00000003);
    wr(8'h4C, 32'hFFFFFFFF);
    rchk(8'h4C, 32'h00000000);
  endtask

  // Clock enable low: a write and a barrier in that cycle are both lost
  task automatic t_freeze;
    @(posedge clk);
    en <= 1'b0;
    reg_addr <= tbrs_pkg::ADR_IRQ_MASK;
    reg_wdata <= 32'h00000003;
    reg_wr <= 1'b1;
    barrier <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    barrier <= 1'b0;
    @(posedge clk);
    en <= 1'b1;
    rchk(tbrs_pkg::ADR_IRQ_MASK, 32'h00000000);
    rchk(tbrs_pkg::ADR_VDEF_STAT, 32'h81FFFFFF);
  endtask

  // Reset in mid-run: views and registers are zero at the release edge
  task automatic t_reset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    #1 chk("walk_base_el1", 48'h000000000000, wb_el1);
    chk("walk_cnp_s2", 48'h000000000000, {47'h0, wcnp2});
    rchk(tbrs_pkg::ADR_S2_CTRL, 32'h00000000);
    rchk(tbrs_pkg::ADR_VDEF_STAT, 32'h00000000);
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      finish_test;
    end
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_bases;
    t_upper;
    t_codes;
    t_errors;
    t_freeze;
    t_reset;
    finish_test;
  end
endmodule
